// ==== logic/vsm_ctrl.v ====
// Video sync and audio mixer control block with Wishbone register slave
// Function
// - Report input none/525/625 lock and reference presence as read-only status
// - Report optical transmitter OK, failed or resetting as read-only status
// - Select 3-line or 5-line comb filter and analog setup present
// - Video gain and chroma gain adjustable from 50 to 150 percent
// - Pedestal level offset limited to plus or minus 5 IRE
// - Hue rotation limited to plus or minus 180 degrees
// - Flag red peak per output when level reaches or exceeds chosen headroom threshold
// - Meter orange above 0 VU, green above -20 VU, else dark
// - Each input channel routes to any output bus with own level
// - Tie channels 1 with 2 and 3 with 4 under one control
// - Per-channel polarity invert and a default command restoring settings
// - Frame sync on with reference: lock output to reference, correct time base
// - Frame sync on without reference: time base correction, free-running output
// - Frame sync off: ignore reference, output follows input, no correction
// - Vertical line and horizontal clock offsets apply only with frame sync on
// - Narrow or wide vertical blanking, end line by line standard
// - Output black, colour bars, or normal video
// - Mute policy: never, mute on noise, or freeze on noise
// - Embed exactly one selected audio group of four
// - Digital reference level of -20 or -18 dBFS
// - Analog reference level of -10 dBu or +4 dBu
// - Peak threshold clipping or 2, 4, 6, 8, 10 dB headroom
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`include "vsm_map.vh"
module vsm_ctrl #(
  parameter NCH = 4,
  parameter AW = 24
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Video and link status
  input wire [1:0] vid_lock_i,
  input wire ref_ok_i,
  input wire [1:0] laser_st_i,
  input wire noise_i,
  // Video control
  output reg comb_5line_o,
  output reg setup_on_o,
  output reg [7:0] gain_pct_o,
  output reg [7:0] chroma_pct_o,
  output reg [7:0] ped_ire_o,
  output reg [8:0] hue_deg_o,
  output reg [1:0] sync_mode_o,
  output reg [9:0] vofs_o,
  output reg [11:0] hofs_o,
  output reg [4:0] blank_last_o,
  output reg [1:0] pattern_o,
  output reg mute_o,
  output reg freeze_o,
  // Audio configuration
  output reg [1:0] group_o,
  output reg dig_ref_o,
  output reg anlg_ref_o,
  output reg [8*NCH-1:0] lvl_o,
  // Audio samples
  input wire aud_stb_i,
  input wire [AW*NCH-1:0] aud_in_i,
  output reg aud_stb_o,
  output reg [AW*NCH-1:0] aud_out_o,
  output reg [2*NCH-1:0] level_meter_o
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Byte lane mask from Wishbone select
  function [31:0] lane_mask;
    input [3:0] sel;
    begin
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // Percent clamp into the 50..150 window
  function [7:0] pct_clamp;
    input [7:0] v;
    begin
      if (v < `VSM_PCT_MIN) begin
        pct_clamp = `VSM_PCT_MIN;
      end else if (v > `VSM_PCT_MAX) begin
        pct_clamp = `VSM_PCT_MAX;
      end else begin
        pct_clamp = v;
      end
    end
  endfunction

  // Peak threshold magnitude by headroom code
  function [AW-1:0] peak_lvl;
    input [2:0] code;
    begin
      case (code)
        3'h0: peak_lvl = `VSM_A_CLIP;
        3'h1: peak_lvl = `VSM_A_M2;
        3'h2: peak_lvl = `VSM_A_M4;
        3'h3: peak_lvl = `VSM_A_M6;
        3'h4: peak_lvl = `VSM_A_M8;
        default: peak_lvl = `VSM_A_M10;
      endcase
    end
  endfunction

  // ****************************************
  // Control registers
  // ****************************************
  reg comb5_r;
  reg setup_r;
  reg [7:0] gain_r;
  reg [7:0] chroma_r;
  reg [7:0] ped_r;
  reg [8:0] hue_r;
  reg fs_on_r;
  reg [9:0] vofs_r;
  reg [11:0] hofs_r;
  reg wide_r;
  reg [1:0] pat_r;
  reg [1:0] mpol_r;
  reg [1:0] grp_r;
  reg dig_r;
  reg anlg_r;
  reg [2:0] peak_r;
  reg [1:0] bus_r [0:NCH-1];
  reg tie_r [0:NCH-1];
  reg inv_r [0:NCH-1];
  reg [7:0] lvl_r [0:NCH-1];
  reg [2*NCH-1:0] meter_r;
  reg [31:0] rd_w;
  reg [1:0] mode_nxt;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [3:0] idx = wb_adr_i[5:2];
  wire [31:0] wr_w = (rd_w & ~lane_mask(wb_sel_i)) | (wb_dat_i & lane_mask(wb_sel_i));
  wire do_wr = wb_req & wb_we_i;
  wire [8:0] hue_w = wr_w[8:0];
  wire [7:0] ped_w = wr_w[7:0];
  wire [1:0] mix_c = idx[1:0] - 2'h2;
  integer c;

  // ****************************************
  // Read mux, also the base for byte merges
  // ****************************************
  always @* begin
    rd_w = 32'h0000_0000;
    case (idx)
      `VSM_R_STATUS: rd_w[4:0] = {laser_st_i, ref_ok_i, vid_lock_i};
      `VSM_R_INCTL: rd_w[1:0] = {setup_r, comb5_r};
      `VSM_R_GAIN: rd_w[7:0] = gain_r;
      `VSM_R_CHROMA: rd_w[7:0] = chroma_r;
      `VSM_R_PED: rd_w[7:0] = ped_r;
      `VSM_R_HUE: rd_w[8:0] = hue_r;
      `VSM_R_TIMCTL: rd_w[2:0] = {sync_mode_o, fs_on_r};
      `VSM_R_OUTCTL: rd_w[4:0] = {mpol_r, pat_r, wide_r};
      `VSM_R_AUDCFG: rd_w[6:0] = {peak_r, anlg_r, dig_r, grp_r};
      `VSM_R_METER: rd_w[2*NCH-1:0] = meter_r;
      `VSM_R_VOFS: rd_w[9:0] = vofs_r;
      `VSM_R_HOFS: rd_w[11:0] = hofs_r;
      default: begin
        if (idx >= `VSM_R_MIX0 && idx < `VSM_R_VOFS) begin
          rd_w[15:0] = {lvl_r[mix_c], 4'h0, inv_r[mix_c], tie_r[mix_c], bus_r[mix_c]};
        end
      end
    endcase
  end

  // ****************************************
  // Wishbone answer, registered ack one cycle after the request
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_w;
      end
    end
  end

  // ****************************************
  // Video and audio configuration writes
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      comb5_r <= 1'b1;
      setup_r <= 1'b0;
      gain_r <= `VSM_PCT_NOM;
      chroma_r <= `VSM_PCT_NOM;
      ped_r <= 8'h00;
      hue_r <= 9'h000;
      fs_on_r <= 1'b1;
      vofs_r <= 10'h000;
      hofs_r <= 12'h000;
      wide_r <= 1'b0;
      pat_r <= 2'h0;
      mpol_r <= 2'h0;
      grp_r <= 2'h0;
      dig_r <= 1'b0;
      anlg_r <= 1'b1;
      peak_r <= 3'h0;
    end else if (do_wr) begin
      case (idx)
        `VSM_R_INCTL: begin
          comb5_r <= wr_w[0];
          setup_r <= wr_w[1];
        end
        `VSM_R_GAIN: gain_r <= pct_clamp(wr_w[7:0]);
        `VSM_R_CHROMA: chroma_r <= pct_clamp(wr_w[7:0]);
        `VSM_R_PED: begin
          if (!ped_w[7] && ped_w > `VSM_PED_LIM) begin
            ped_r <= `VSM_PED_LIM;
          end else if (ped_w[7] && ped_w < (8'h00 - `VSM_PED_LIM)) begin
            ped_r <= 8'h00 - `VSM_PED_LIM;
          end else begin
            ped_r <= ped_w;
          end
        end
        `VSM_R_HUE: begin
          if (!hue_w[8] && hue_w > `VSM_HUE_LIM) begin
            hue_r <= `VSM_HUE_LIM;
          end else if (hue_w[8] && hue_w < (9'h000 - `VSM_HUE_LIM)) begin
            hue_r <= 9'h000 - `VSM_HUE_LIM;
          end else begin
            hue_r <= hue_w;
          end
        end
        `VSM_R_TIMCTL: fs_on_r <= wr_w[0];
        `VSM_R_VOFS: vofs_r <= wr_w[9:0];
        `VSM_R_HOFS: hofs_r <= wr_w[11:0];
        // pattern, unused code falls to off
        `VSM_R_OUTCTL: begin
          wide_r <= wr_w[`VSM_OUT_WIDE];
          pat_r <= (wr_w[2:1] == 2'h3) ? 2'h0 : wr_w[2:1];
          mpol_r <= (wr_w[4:3] == 2'h3) ? 2'h0 : wr_w[4:3];
        end
        // headroom codes above ten dB are held at ten
        `VSM_R_AUDCFG: begin
          grp_r <= wr_w[1:0];
          dig_r <= wr_w[`VSM_AUD_DIG];
          anlg_r <= wr_w[`VSM_AUD_ANLG];
          peak_r <= (wr_w[6:4] > `VSM_PEAK_MAX) ? `VSM_PEAK_MAX : wr_w[6:4];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Mixer channel settings
  // ****************************************
  // A tied pair shares level and polarity; writing either side updates both
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (c = 0; c < NCH; c = c + 1) begin
        bus_r[c] <= c[1:0];
        tie_r[c] <= 1'b0;
        inv_r[c] <= 1'b0;
        lvl_r[c] <= 8'h00;
      end
    end else if (do_wr && idx >= `VSM_R_MIX0 && idx < `VSM_R_VOFS) begin
      if (wr_w[`VSM_MIX_DFLT]) begin
        bus_r[mix_c] <= mix_c;
        tie_r[mix_c] <= 1'b0;
        inv_r[mix_c] <= 1'b0;
        lvl_r[mix_c] <= 8'h00;
        tie_r[mix_c ^ 2'h1] <= 1'b0;
      end else begin
        bus_r[mix_c] <= wr_w[1:0];
        lvl_r[mix_c] <= wr_w[15:8];
        inv_r[mix_c] <= wr_w[`VSM_MIX_INV];
        tie_r[mix_c] <= wr_w[`VSM_MIX_TIE];
        tie_r[mix_c ^ 2'h1] <= wr_w[`VSM_MIX_TIE];
        if (wr_w[`VSM_MIX_TIE]) begin
          lvl_r[mix_c ^ 2'h1] <= wr_w[15:8];
          inv_r[mix_c ^ 2'h1] <= wr_w[`VSM_MIX_INV];
        end
      end
    end
  end

  // ****************************************
  // Video control and audio configuration outputs
  // ****************************************
  always @* begin
    // frame sync off passes input timing
    // no reference gives time base correction only
    if (!fs_on_r) begin
      mode_nxt = 2'h0;
    end else if (!ref_ok_i) begin
      mode_nxt = 2'h1;
    end else begin
      mode_nxt = 2'h2;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      comb_5line_o <= 1'b1;
      setup_on_o <= 1'b0;
      gain_pct_o <= `VSM_PCT_NOM;
      chroma_pct_o <= `VSM_PCT_NOM;
      ped_ire_o <= 8'h00;
      hue_deg_o <= 9'h000;
      sync_mode_o <= 2'h0;
      vofs_o <= 10'h000;
      hofs_o <= 12'h000;
      blank_last_o <= `VSM_BLK_525N;
      pattern_o <= 2'h0;
      mute_o <= 1'b0;
      freeze_o <= 1'b0;
      group_o <= 2'h0;
      dig_ref_o <= 1'b0;
      anlg_ref_o <= 1'b1;
    end else begin
      comb_5line_o <= comb5_r;
      setup_on_o <= setup_r;
      gain_pct_o <= gain_r;
      chroma_pct_o <= chroma_r;
      ped_ire_o <= ped_r;
      hue_deg_o <= hue_r;
      sync_mode_o <= mode_nxt;
      vofs_o <= fs_on_r ? vofs_r : 10'h000;
      hofs_o <= fs_on_r ? hofs_r : 12'h000;
      // blanking end line; no lock uses 525 figures
      if (vid_lock_i == `VSM_STD_625) begin
        blank_last_o <= wide_r ? `VSM_BLK_625W : `VSM_BLK_625N;
      end else begin
        blank_last_o <= wide_r ? `VSM_BLK_525W : `VSM_BLK_525N;
      end
      pattern_o <= pat_r;
      // mute or freeze only while noisy
      mute_o <= (mpol_r == 2'h1) & noise_i;
      freeze_o <= (mpol_r == 2'h2) & noise_i;
      group_o <= grp_r;
      dig_ref_o <= dig_r;
      anlg_ref_o <= anlg_r;
    end
  end

  // ****************************************
  // Mixer buses and level meters
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gch
      reg signed [AW+1:0] acc;
      reg signed [AW+1:0] smp;
      reg [AW:0] mag;
      integer k;

      always @(posedge clk_i) begin
        if (rst_i) begin
          lvl_o[8*g +: 8] <= 8'h00;
        end else begin
          lvl_o[8*g +: 8] <= lvl_r[g];
        end
      end

      // Sum of every input routed to this bus, invert applied, saturated
      always @* begin
        acc = {(AW+2){1'b0}};
        smp = {(AW+2){1'b0}};
        for (k = 0; k < NCH; k = k + 1) begin
          smp = {{2{aud_in_i[AW*k+AW-1]}}, aud_in_i[AW*k +: AW]};
          if ({30'h0, bus_r[k]} == g) begin
            acc = inv_r[k] ? acc - smp : acc + smp;
          end
        end
      end

      always @(posedge clk_i) begin
        if (rst_i) begin
          aud_out_o[AW*g +: AW] <= {AW{1'b0}};
        end else if (aud_stb_i) begin
          if (acc > $signed({3'b000, {(AW-1){1'b1}}})) begin
            aud_out_o[AW*g +: AW] <= {1'b0, {(AW-1){1'b1}}};
          end else if (acc < $signed({3'b111, {(AW-1){1'b0}}})) begin
            aud_out_o[AW*g +: AW] <= {1'b1, {(AW-1){1'b0}}};
          end else begin
            aud_out_o[AW*g +: AW] <= acc[AW-1:0];
          end
        end
      end

      // Magnitude of the bus sample just produced
      always @* begin
        if (aud_out_o[AW*g+AW-1]) begin
          mag = {1'b0, ~aud_out_o[AW*g +: AW]} + {{AW{1'b0}}, 1'b1};
        end else begin
          mag = {1'b0, aud_out_o[AW*g +: AW]};
        end
      end

      // Meter codes: 0 dark, 1 green, 2 orange, 3 red
      always @(posedge clk_i) begin
        if (rst_i) begin
          meter_r[2*g +: 2] <= 2'h0;
        end else if (aud_stb_o) begin
          if (mag >= {1'b0, peak_lvl(peak_r)}) begin
            meter_r[2*g +: 2] <= 2'h3;
          end else if (mag > {1'b0, dig_r ? `VSM_A_M18 : `VSM_A_M20}) begin
            meter_r[2*g +: 2] <= 2'h2;
          end else if (mag > {1'b0, dig_r ? `VSM_A_M38 : `VSM_A_M40}) begin
            meter_r[2*g +: 2] <= 2'h1;
          end else begin
            meter_r[2*g +: 2] <= 2'h0;
          end
        end
      end
    end
  endgenerate

  // Sample strobe in step with the bus samples; meter out two cycles behind them
  always @(posedge clk_i) begin
    if (rst_i) begin
      aud_stb_o <= 1'b0;
      level_meter_o <= {(2*NCH){1'b0}};
    end else begin
      aud_stb_o <= aud_stb_i;
      level_meter_o <= meter_r;
    end
  end

endmodule

// ==== logic/vsm_map.vh ====
// Register offsets, field positions, reset values and level thresholds
`ifndef VSM_MAP_VH
`define VSM_MAP_VH
// ****************************************
// Register word indexes (byte address = 4 x index)
// ****************************************
`define VSM_R_STATUS 4'h0
`define VSM_R_INCTL 4'h1
`define VSM_R_GAIN 4'h2
`define VSM_R_CHROMA 4'h3
`define VSM_R_PED 4'h4
`define VSM_R_HUE 4'h5
`define VSM_R_TIMCTL 4'h6
`define VSM_R_OUTCTL 4'h7
`define VSM_R_AUDCFG 4'h8
`define VSM_R_METER 4'h9
`define VSM_R_MIX0 4'ha
`define VSM_R_VOFS 4'he
`define VSM_R_HOFS 4'hf
// ****************************************
// Field positions
// ****************************************
`define VSM_MIX_INV 3
`define VSM_MIX_TIE 2
`define VSM_MIX_DFLT 4
`define VSM_OUT_WIDE 0
`define VSM_AUD_DIG 2
`define VSM_AUD_ANLG 3
// ****************************************
// Reset values and limits
// ****************************************
`define VSM_PCT_NOM 8'h64
`define VSM_PCT_MIN 8'h32
`define VSM_PCT_MAX 8'h96
`define VSM_PED_LIM 8'h05
`define VSM_HUE_LIM 9'h0b4
`define VSM_PEAK_MAX 3'h5
`define VSM_STD_525 2'h1
`define VSM_STD_625 2'h2
`define VSM_BLK_525N 5'h09
`define VSM_BLK_525W 5'h14
`define VSM_BLK_625N 5'h06
`define VSM_BLK_625W 5'h16
// ****************************************
// Audio magnitudes on a 24-bit full scale
// ****************************************
`define VSM_A_CLIP 24'h7f_ffff
`define VSM_A_M2 24'h65_ac28
`define VSM_A_M4 24'h50_c3a8
`define VSM_A_M6 24'h40_26e6
`define VSM_A_M8 24'h32_f52c
`define VSM_A_M10 24'h28_7a6d
`define VSM_A_M18 24'h10_1d35
`define VSM_A_M20 24'h0c_ccce
`define VSM_A_M38 24'h01_9c85
`define VSM_A_M40 24'h01_47ae
`endif

// ==== tb/vsm_ctrl_asserts.sv ====
// Port-level assertions for the control block
module vsm_ctrl_asserts #(
  parameter NCH = 4,
  parameter AW = 24
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire noise_i,
  input wire aud_stb_i,
  input wire aud_stb_o,
  input wire [7:0] gain_pct_o,
  input wire [7:0] chroma_pct_o,
  input wire [7:0] ped_ire_o,
  input wire [8:0] hue_deg_o,
  input wire [1:0] sync_mode_o,
  input wire [9:0] vofs_o,
  input wire [11:0] hofs_o,
  input wire [4:0] blank_last_o,
  input wire [1:0] pattern_o,
  input wire mute_o,
  input wire freeze_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Checks, all in the one clock domain
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_aud_one_lag: assert property (aud_stb_i |=> aud_stb_o && !$past(aud_stb_o))
    else $error("audio strobe not passed on");
  a_aud_out_cause: assert property (aud_stb_o |-> $past(aud_stb_i))
    else $error("audio strobe without input");
  a_gain_in_range: assert property (gain_pct_o inside {[50:150]} && chroma_pct_o inside {[50:150]})
    else $error("gain out of range");
  a_ped_in_range: assert property ($signed(ped_ire_o) >= -5 && $signed(ped_ire_o) <= 5)
    else $error("pedestal out of range");
  a_hue_in_range: assert property ($signed(hue_deg_o) >= -180 && $signed(hue_deg_o) <= 180)
    else $error("hue out of range");
  a_ofs_fs_off: assert property (sync_mode_o == 2'h0 |-> vofs_o == 10'h0 && hofs_o == 12'h0)
    else $error("offset applied with frame sync off");
  a_blank_legal: assert property (blank_last_o inside {5'h09, 5'h14, 5'h06, 5'h16})
    else $error("illegal blanking end line");
  a_codes_legal: assert property (sync_mode_o != 2'h3 && pattern_o != 2'h3)
    else $error("illegal mode or pattern code");
  a_mute_on_noise: assert property (mute_o || freeze_o |-> $past(noise_i) && !(mute_o && freeze_o))
    else $error("mute or freeze without noise");
  c_ack: cover property (wb_ack_o);
  c_audio: cover property (aud_stb_o);
  c_ref_lock: cover property (sync_mode_o == 2'h2);
  c_mute: cover property (mute_o);
endmodule

bind vsm_ctrl vsm_ctrl_asserts #(.NCH(NCH), .AW(AW)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .noise_i(noise_i),
  .aud_stb_i(aud_stb_i), .aud_stb_o(aud_stb_o), .gain_pct_o(gain_pct_o),
  .chroma_pct_o(chroma_pct_o), .ped_ire_o(ped_ire_o), .hue_deg_o(hue_deg_o),
  .sync_mode_o(sync_mode_o), .vofs_o(vofs_o), .hofs_o(hofs_o), .blank_last_o(blank_last_o),
  .pattern_o(pattern_o), .mute_o(mute_o), .freeze_o(freeze_o));

// ==== tb/vsm_far.sv ====
// Far side model: audio converter handing samples to the block
module vsm_far #(
  parameter W = 96
) (
  input wire clk_i,
  input wire go_i,
  input wire [W-1:0] smp_i,
  output logic stb_o,
  output logic [W-1:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Defined levels at time zero
  initial begin
    stb_o = 1'b0;
    dat_o = '0;
  end
  // samples valid with strobe
  // Between strobes the bus toggles so stale samples are never mistaken
  always @(posedge clk_i) begin
    stb_o <= go_i;
    dat_o <= go_i ? smp_i : ~dat_o;
  end
endmodule

// ==== tb/test_video_sync_audio_mixer_control.sv ====
// Self-checking bench for the video sync and audio mixer control block
module test_video_sync_audio_mixer_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ref_ok = 1'b0, noise = 1'b0, go = 1'b0;
  logic [5:0] adr = 6'h0;
  logic [31:0] wdat = 32'h0, q, rdat, lvl;
  logic [3:0] sel = 4'hf, lanes = 4'hf;
  logic [1:0] vid = 2'h0, laser = 2'h0, mode, pat, grp;
  logic [95:0] smp = 96'h0, aud_in, aud_out;
  logic ack, comb5, setup, mute, freeze, dig, anlg, aud_si, aud_so;
  logic [7:0] gain, chroma, ped, meter;
  logic [8:0] hue;
  logic [9:0] vofs;
  logic [11:0] hofs;
  logic [4:0] blank;
  int failures = 0, total_checks = 0;

  vsm_ctrl #(.NCH(4), .AW(24)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .vid_lock_i(vid), .ref_ok_i(ref_ok), .laser_st_i(laser),
    .noise_i(noise), .comb_5line_o(comb5), .setup_on_o(setup), .gain_pct_o(gain),
    .chroma_pct_o(chroma), .ped_ire_o(ped), .hue_deg_o(hue), .sync_mode_o(mode), .vofs_o(vofs),
    .hofs_o(hofs), .blank_last_o(blank), .pattern_o(pat), .mute_o(mute), .freeze_o(freeze),
    .group_o(grp), .dig_ref_o(dig), .anlg_ref_o(anlg), .lvl_o(lvl), .aud_stb_i(aud_si),
    .aud_in_i(aud_in), .aud_stb_o(aud_so), .aud_out_o(aud_out), .level_meter_o(meter));
  vsm_far #(.W(96)) far_u (.clk_i(clk_i), .go_i(go), .smp_i(smp), .stb_o(aud_si),
    .dat_o(aud_in));

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  // ****
  // Shared tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle: held until ack is sampled high, data taken at that edge
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= lanes;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // Let registered outputs follow a change
  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask
  // Send one sample set; bus out one cycle after, meter two cycles after that
  task automatic aud(input logic [95:0] s, input logic [95:0] e, input logic [7:0] m);
    int n;
    @(posedge clk_i);
    smp <= s;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (aud_so !== 1'b1 && n < 20);
    for (int k = 0; k < 4; k++) chk("bus", {8'h0, e[24*k+:24]}, {8'h0, aud_out[24*k+:24]});
    repeat (2) @(posedge clk_i);
    chk("meter", {24'h0, m}, {24'h0, meter});
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rdc(6'h08, 32'h64, "gain");
    rdc(6'h04, 32'h1, "inctl");
    rdc(6'h20, 32'h8, "audcfg");
    chk("blank", 32'h9, blank);
  endtask
  task automatic t_status;
    for (int v = 0; v < 3; v++) begin
      vid <= v[1:0];
      laser <= v[1:0];
      ref_ok <= v[0];
      settle;
      rdc(6'h00, {27'h0, v[1:0], v[0], v[1:0]}, "status");
    end
    wr(6'h00, 32'h1f);
    rdc(6'h00, 32'h12, "status");
  endtask
  task automatic t_proc;
    wr(6'h04, 32'h2);
    wr(6'h08, 32'hc8);
    wr(6'h0c, 32'h0a);
    wr(6'h10, 32'hf0);
    wr(6'h14, 32'h0c8);
    settle;
    chk("comb5", 32'h0, comb5);
    chk("setup", 32'h1, setup);
    chk("gain", 32'h96, gain);
    chk("chroma", 32'h32, chroma);
    chk("ped", 32'hfb, ped);
    chk("hue", 32'hb4, hue);
    wr(6'h14, 32'h138);
    wr(6'h10, 32'h3);
    settle;
    chk("hue", 32'h14c, hue);
    chk("ped", 32'h3, ped);
    // Byte lane merge: only the low lane of the offset may change
    lanes = 4'h1;
    wr(6'h3c, 32'h0000_0a12);
    lanes = 4'hf;
    rdc(6'h3c, 32'h12, "hofs_lane");
  endtask
  task automatic t_timing;
    ref_ok <= 1'b1;
    wr(6'h38, 32'h5);
    wr(6'h3c, 32'h7);
    wr(6'h18, 32'h1);
    settle;
    chk("mode", 32'h2, mode);
    chk("vofs", 32'h5, vofs);
    chk("hofs", 32'h7, hofs);
    rdc(6'h18, 32'h5, "timctl");
    ref_ok <= 1'b0;
    settle;
    chk("mode", 32'h1, mode);
    wr(6'h18, 32'h0);
    ref_ok <= 1'b1;
    settle;
    chk("mode", 32'h0, mode);
    chk("vofs", 32'h0, vofs);
  endtask
  task automatic t_output;
    vid <= 2'h1;
    wr(6'h1c, 32'h1);
    settle;
    chk("blank", 32'h14, blank);
    vid <= 2'h2;
    settle;
    chk("blank", 32'h16, blank);
    wr(6'h1c, 32'h0);
    settle;
    chk("blank", 32'h6, blank);
    for (int p = 0; p < 4; p++) begin
      wr(6'h1c, 32'(p) << 1);
      settle;
      chk("pattern", (p == 3) ? 32'h0 : 32'(p), pat);
    end
    noise <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      wr(6'h1c, 32'(m) << 3);
      settle;
      chk("mute", {31'h0, m == 1}, mute);
      chk("freeze", {31'h0, m == 2}, freeze);
    end
    noise <= 1'b0;
    settle;
    chk("freeze", 32'h0, freeze);
  endtask
  task automatic t_audcfg;
    for (int g = 0; g < 4; g++) begin
      wr(6'h20, 32'h70 | 32'(g) | (32'(g) << 2));
      settle;
      chk("group", 32'(g), grp);
      chk("dig", 32'(g & 1), dig);
      chk("anlg", 32'(g >> 1), anlg);
    end
    rdc(6'h20, 32'h5f, "audcfg");
  endtask
  task automatic t_mix;
    wr(6'h20, 32'h58);
    wr(6'h28, 32'h1);
    wr(6'h2c, 32'h0);
    wr(6'h30, 32'ha);
    aud({24'h10, 24'h02_0000, 24'h20, 24'h30}, {24'h10, 24'hfe_0000, 24'h30, 24'h20}, 8'h10);
    wr(6'h28, 32'h30d);
    rdc(6'h2c, 32'h30c, "mix2");
    chk("lvl", 32'h0000_0303, lvl);
    wr(6'h28, 32'h10);
    rdc(6'h28, 32'h0, "mix1");
    wb(1'b0, 6'h2c, 32'h0);
    chk("tie2", 32'h0, {31'h0, q[2]});
    wr(6'h2c, 32'h10);
    wr(6'h30, 32'h10);
    aud({24'h100, 24'h02_0000, 24'h10_0000, 24'h30_0000},
      {24'h100, 24'h02_0000, 24'h10_0000, 24'h30_0000}, 8'h1b);
    wr(6'h20, 32'h08);
    aud({24'h100, 24'h02_0000, 24'h10_0000, 24'h30_0000},
      {24'h100, 24'h02_0000, 24'h10_0000, 24'h30_0000}, 8'h1a);
    wr(6'h20, 32'h0c);
    aud({24'h100, 24'h02_0000, 24'h10_0000, 24'h30_0000},
      {24'h100, 24'h02_0000, 24'h10_0000, 24'h30_0000}, 8'h16);
  endtask

  // ****
  // Run and verdict
  // ****
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence after a two cycle reset
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_status;
    t_proc;
    t_timing;
    t_output;
    t_audcfg;
    t_mix;
    end_sim;
  end
  // Watchdog, well beyond the expected run of a few hundred cycles
  initial begin
    #200_000;
    failures++;
    end_sim;
  end
endmodule
